// ==== ebi_pkg.sv ====
// Behaviour
// - Three chip selects, one per external area, asserted independently.
// - Separate address and data pins; a bus cycle lasts at least two bus clocks.
// - Each chip-select area has an 8-bit or 16-bit data width.
// - Each area inserts zero to seven programmed data wait states.
// - External wait input stretches the bus cycle while asserted.
// - Internal accesses leave strobes inactive and data pins undriven.
// - A write to the internal ROM range runs as an external write.
// - Blocks of 2 MB, 2 MB and 4 MB each carry their own settings.
// - Each area decodes 512 KB; the rest of its block aliases onto it.
// - Input-mode pins: writes update the latch, reads return the pin.
// - Bit operations read a byte, modify one bit, write the byte back.
// - Data pin mode bit set makes the pin a bus data line.
// - External wait is sampled after the first bus state and waits.
// - A wait state is inserted when the count or the wait input asks.
// - Optional idle state after the second bus state of reads only.
package ebi_pkg;
  localparam int          ADDR_W    = 26;
  localparam int          PIN_A_W   = 19;
  localparam int          DATA_W    = 16;
  localparam int          PORT_W    = 16;
  localparam int          WAIT_W    = 3;
  localparam int          MIN_BUS_CLKS  = 2;
  localparam int          MCLK_PER_BCLK = 2;
  localparam logic [25:0] ROM_LIMIT = 26'h0100000;
  localparam logic [25:0] BLK1_BASE = 26'h0200000;
  localparam logic [25:0] BLK2_BASE = 26'h0400000;
  localparam logic [25:0] BLK_TOP   = 26'h0800000;
  localparam logic [1:0]  AREA_ROM  = 2'h3;
  localparam logic [1:0]  REG_LATCH = 2'h0;
  localparam logic [1:0]  REG_DIR   = 2'h1;
  localparam logic [1:0]  REG_MODE  = 2'h2;
  localparam logic [1:0]  REG_FUNC  = 2'h3;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [15:0] DIR_RST   = 16'hffff;
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] FUNC_RST  = 16'h0000;
  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_TW, ST_T2, ST_TI} ebi_state_e;
endpackage

// ==== ebi_port_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Software access to one port and the register contents it exposes
interface ebi_port_if;
  logic        wr;
  logic        bit_op;
  logic [1:0]  regsel;
  logic        half;
  logic        wide;
  logic [2:0]  bitnum;
  logic        bitval;
  logic [15:0] wdata;
  logic [15:0] pin_in;
  logic [15:0] rdata;
  logic [15:0] latch;
  logic [15:0] dir;
  logic [15:0] mode;
  logic [15:0] func;
  modport ctl  (output wr, bit_op, regsel, half, wide, bitnum, bitval,
                wdata, pin_in, input rdata, latch, dir, mode, func);
  modport port (input wr, bit_op, regsel, half, wide, bitnum, bitval,
                wdata, pin_in, output rdata, latch, dir, mode, func);
endinterface
`default_nettype wire

// ==== ebi_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module ebi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s1_next;
  logic [WIDTH-1:0] q_next;

  // Stage one feeds only stage two
  always_comb begin
    s1_next = ce ? d : s1_reg;
    q_next  = ce ? s1_reg : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= s1_next;
      q      <= q_next;
    end
  end
endmodule // ebi_sync
`default_nettype wire

// ==== ebi_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module ebi_port (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  ebi_port_if.port  pif
);
  logic [3:0][15:0] r_reg;
  logic [3:0][15:0] r_next;
  logic [15:0]      rdata_reg;
  logic [15:0]      rdata_next;
  logic [15:0]      view;
  logic [15:0]      cur;
  logic [7:0]       b;

  // Input pins read as pin level, output pins as latch
  always_comb begin
    view = (r_reg[ebi_pkg::REG_LATCH] & ~r_reg[ebi_pkg::REG_DIR])
         | (pif.pin_in & r_reg[ebi_pkg::REG_DIR]);
    cur  = (pif.regsel == ebi_pkg::REG_LATCH) ? view : r_reg[pif.regsel];
    b    = pif.half ? cur[15:8] : cur[7:0];
    if (pif.bit_op) begin
      b[pif.bitnum] = pif.bitval;
    end else begin
      b = pif.wdata[7:0];
    end
    r_next     = r_reg;
    rdata_next = ce ? cur : rdata_reg;
    // Byte write-back can copy input levels into the latch
    if (ce && pif.wr) begin
      if (pif.wide && !pif.bit_op) begin
        r_next[pif.regsel] = pif.wdata;
      end else if (pif.half) begin
        r_next[pif.regsel][15:8] = b;
      end else begin
        r_next[pif.regsel][7:0] = b;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg[0]  <= ebi_pkg::LATCH_RST;
      r_reg[1]  <= ebi_pkg::DIR_RST;
      r_reg[2]  <= ebi_pkg::MODE_RST;
      r_reg[3]  <= ebi_pkg::FUNC_RST;
      rdata_reg <= '0;
    end else begin
      r_reg     <= r_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pif.rdata = rdata_reg;
  assign pif.latch = r_reg[0];
  assign pif.dir   = r_reg[1];
  assign pif.mode  = r_reg[2];
  assign pif.func  = r_reg[3];
endmodule // ebi_port
`default_nettype wire

// ==== ebi_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ebi_top (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        REQ,
  input  wire logic        REQ_WR,
  input  wire logic        REQ_HALF,
  input  wire logic [25:0] REQ_ADDR,
  input  wire logic [15:0] REQ_WDATA,
  output var  logic        REQ_READY,
  output var  logic        REQ_DONE,
  output var  logic [15:0] REQ_RDATA,
  input  wire logic [2:0]  AREA_BUS16,
  input  wire logic [8:0]  AREA_WAITS,
  input  wire logic [2:0]  AREA_IDLE_EN,
  input  wire logic        CTRL_PIN_EN,
  input  wire logic        PORT_WR,
  input  wire logic        PORT_TGT_DL,
  input  wire logic        PORT_BIT,
  input  wire logic [1:0]  PORT_REG,
  input  wire logic        PORT_HALF,
  input  wire logic        PORT_WIDE,
  input  wire logic [2:0]  PORT_BITNUM,
  input  wire logic        PORT_BITVAL,
  input  wire logic [15:0] PORT_WDATA,
  output var  logic [15:0] PORT_RDATA,
  input  wire logic [15:0] P9_IN,
  output var  logic [15:0] P9_OUT,
  output var  logic [15:0] P9_OE,
  input  wire logic [15:0] DL_IN,
  output var  logic [15:0] DL_OUT,
  output var  logic [15:0] DL_OE,
  output var  logic [2:0]  ADDR_HI,
  output var  logic [2:0]  CS_N,
  output var  logic        WR_LO_N,
  output var  logic        WR_HI_N,
  output var  logic        RD_N,
  output var  logic        BUS_CLK,
  input  wire logic        WAIT_N
);
  ebi_port_if p9_if ();
  ebi_port_if dl_if ();

  logic [15:0] p9_s;
  logic [15:0] dl_s;
  logic        wait_s;

  ebi_pkg::ebi_state_e st_reg;
  ebi_pkg::ebi_state_e st_next;
  logic        bclk_reg;
  logic        bclk_next;
  logic        clk_out_reg;
  logic        clk_out_next;
  logic [18:0] addr_reg;
  logic [18:0] addr_next;
  logic [15:0] dout_reg;
  logic [15:0] dout_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [1:0]  area_reg;
  logic [1:0]  area_next;
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  logic        wr_reg;
  logic        wr_next;
  logic        lane_lo_reg;
  logic        lane_lo_next;
  logic        lane_hi_reg;
  logic        lane_hi_next;
  logic        idle_en_reg;
  logic        idle_en_next;
  logic        bus16_reg;
  logic        bus16_next;
  logic        done_reg;
  logic        done_next;
  logic [2:0]  cs_n_reg;
  logic [2:0]  cs_n_next;
  logic        wr_lo_n_reg;
  logic        wr_lo_n_next;
  logic        wr_hi_n_reg;
  logic        wr_hi_n_next;
  logic        rd_n_reg;
  logic        rd_n_next;
  logic        drive_reg;
  logic        drive_next;
  logic        tick;
  logic        take;
  logic        ext;
  logic [1:0]  area;
  logic        bus16;
  logic        active_next;

  // Pins from outside pass two flops before use; wait is inverted first
  // so the cleared flops read as no wait straight after reset
  ebi_sync #(.WIDTH(33)) u_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .ce    (CE),
    .d     ({~WAIT_N, DL_IN, P9_IN}),
    .q     ({wait_s, dl_s, p9_s})
  );

  // Software port access steered to one of the two ports
  always_comb begin
    p9_if.wr     = PORT_WR && !PORT_TGT_DL;
    dl_if.wr     = PORT_WR && PORT_TGT_DL;
    p9_if.pin_in = p9_s;
    dl_if.pin_in = dl_s;
    {p9_if.bit_op, dl_if.bit_op} = {2{PORT_BIT}};
    {p9_if.regsel, dl_if.regsel} = {2{PORT_REG}};
    {p9_if.half, dl_if.half}     = {2{PORT_HALF}};
    {p9_if.wide, dl_if.wide}     = {2{PORT_WIDE}};
    {p9_if.bitnum, dl_if.bitnum} = {2{PORT_BITNUM}};
    {p9_if.bitval, dl_if.bitval} = {2{PORT_BITVAL}};
    {p9_if.wdata, dl_if.wdata}   = {2{PORT_WDATA}};
    PORT_RDATA = PORT_TGT_DL ? dl_if.rdata : p9_if.rdata;
  end

  ebi_port u_p9 (.clk(MCLK), .rst_n(RST_N), .ce(CE), .pif(p9_if.port));
  ebi_port u_dl (.clk(MCLK), .rst_n(RST_N), .ce(CE), .pif(dl_if.port));

  // Area decode; only the low 19 bits reach the pins, hence aliasing
  always_comb begin
    ext  = 1'b1;
    area = ebi_pkg::AREA_ROM;
    if (REQ_ADDR < ebi_pkg::ROM_LIMIT) begin
      ext = REQ_WR;
    end else if (REQ_ADDR < ebi_pkg::BLK1_BASE) begin
      area = 2'h0;
    end else if (REQ_ADDR < ebi_pkg::BLK2_BASE) begin
      area = 2'h1;
    end else if (REQ_ADDR < ebi_pkg::BLK_TOP) begin
      area = 2'h2;
    end else begin
      ext = 1'b0;
    end
  end
  // ROM-range writes borrow block zero settings
  assign bus16 = AREA_BUS16[(area == ebi_pkg::AREA_ROM) ? 2'h0 : area];

  assign tick      = bclk_reg;
  assign REQ_READY = (st_reg == ebi_pkg::ST_IDLE) && tick && CE;
  assign take      = REQ && REQ_READY;

  // Bus sequencer: one state per bus clock
  always_comb begin
    bclk_next    = CE ? ~bclk_reg : bclk_reg;
    st_next      = st_reg;
    addr_next    = addr_reg;
    dout_next    = dout_reg;
    rdata_next   = rdata_reg;
    area_next    = area_reg;
    cnt_next     = cnt_reg;
    wr_next      = wr_reg;
    lane_lo_next = lane_lo_reg;
    lane_hi_next = lane_hi_reg;
    idle_en_next = idle_en_reg;
    bus16_next   = bus16_reg;
    done_next    = CE ? 1'b0 : done_reg;
    if (CE && tick) begin
      case (st_reg)
        ebi_pkg::ST_IDLE: begin
          if (take && !ext) begin
            done_next = 1'b1;
          end else if (take) begin
            st_next   = ebi_pkg::ST_T1;
            addr_next = REQ_ADDR[18:0];
            area_next = area;
            wr_next   = REQ_WR;
            bus16_next = bus16;
            lane_lo_next = !bus16 || REQ_HALF || !REQ_ADDR[0];
            lane_hi_next = bus16 && (REQ_HALF || REQ_ADDR[0]);
            dout_next = REQ_HALF ? REQ_WDATA : {2{REQ_WDATA[7:0]}};
            cnt_next  = (area == ebi_pkg::AREA_ROM) ? AREA_WAITS[2:0]
                      : AREA_WAITS[area*3 +: 3];
            idle_en_next = AREA_IDLE_EN[(area == ebi_pkg::AREA_ROM)
                                        ? 2'h0 : area];
          end
        end
        ebi_pkg::ST_T1, ebi_pkg::ST_TW: begin
          if (st_reg == ebi_pkg::ST_TW && cnt_reg != 3'h0) begin
            cnt_next = cnt_reg - 3'h1;
          end
          if ((st_reg == ebi_pkg::ST_T1 && cnt_reg != 3'h0)
              || (st_reg == ebi_pkg::ST_TW && cnt_reg > 3'h1)
              || wait_s) begin
            st_next = ebi_pkg::ST_TW;
          end else begin
            st_next = ebi_pkg::ST_T2;
          end
        end
        ebi_pkg::ST_T2: begin
          done_next = 1'b1;
          if (!wr_reg) begin
            rdata_next = !bus16_reg ? {8'h00, dl_s[7:0]}
                       : (lane_lo_reg ? (lane_hi_reg ? dl_s
                       : {8'h00, dl_s[7:0]}) : {8'h00, dl_s[15:8]});
          end
          st_next = (!wr_reg && idle_en_reg) ? ebi_pkg::ST_TI
                  : ebi_pkg::ST_IDLE;
        end
        default: st_next = ebi_pkg::ST_IDLE;
      endcase
    end
  end

  // Strobes registered from the next state so the pins never glitch
  always_comb begin
    active_next  = (st_next == ebi_pkg::ST_T1) || (st_next == ebi_pkg::ST_TW)
                || (st_next == ebi_pkg::ST_T2);
    cs_n_next    = 3'h7;
    if (active_next && area_next != ebi_pkg::AREA_ROM) begin
      cs_n_next[area_next] = 1'b0;
    end
    rd_n_next    = !(active_next && !wr_next);
    wr_lo_n_next = !(active_next && wr_next && lane_lo_next);
    wr_hi_n_next = !(active_next && wr_next && lane_hi_next);
    drive_next   = active_next && wr_next;
    clk_out_next = bclk_next && CTRL_PIN_EN;
    if (!CTRL_PIN_EN) begin
      cs_n_next    = 3'h7;
      rd_n_next    = 1'b1;
      wr_lo_n_next = 1'b1;
      wr_hi_n_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg      <= ebi_pkg::ST_IDLE;
      bclk_reg    <= 1'b0;
      clk_out_reg <= 1'b0;
      addr_reg    <= '0;
      dout_reg    <= '0;
      rdata_reg   <= '0;
      area_reg    <= 2'h0;
      cnt_reg     <= 3'h0;
      wr_reg      <= 1'b0;
      lane_lo_reg <= 1'b0;
      lane_hi_reg <= 1'b0;
      idle_en_reg <= 1'b0;
      bus16_reg   <= 1'b0;
      done_reg    <= 1'b0;
      cs_n_reg    <= 3'h7;
      wr_lo_n_reg <= 1'b1;
      wr_hi_n_reg <= 1'b1;
      rd_n_reg    <= 1'b1;
      drive_reg   <= 1'b0;
    end else begin
      st_reg      <= st_next;
      bclk_reg    <= bclk_next;
      clk_out_reg <= clk_out_next;
      addr_reg    <= addr_next;
      dout_reg    <= dout_next;
      rdata_reg   <= rdata_next;
      area_reg    <= area_next;
      cnt_reg     <= cnt_next;
      wr_reg      <= wr_next;
      lane_lo_reg <= lane_lo_next;
      lane_hi_reg <= lane_hi_next;
      idle_en_reg <= idle_en_next;
      bus16_reg   <= bus16_next;
      done_reg    <= done_next;
      cs_n_reg    <= cs_n_next;
      wr_lo_n_reg <= wr_lo_n_next;
      wr_hi_n_reg <= wr_hi_n_next;
      rd_n_reg    <= rd_n_next;
      drive_reg   <= drive_next;
    end
  end

  // Pin multiplexing per bit; latch rewrite before output is software's job
  genvar j;
  generate
    for (j = 0; j < 16; j++) begin : g_pin
      logic a_fn;
      assign a_fn = p9_if.mode[j] && !p9_if.func[j];
      assign P9_OUT[j] = a_fn ? addr_reg[j] : p9_if.latch[j];
      assign P9_OE[j]  = a_fn || (!p9_if.mode[j] && !p9_if.dir[j]);
      assign DL_OUT[j] = dl_if.mode[j] ? dout_reg[j] : dl_if.latch[j];
      assign DL_OE[j]  = dl_if.mode[j] ? drive_reg
                       : !dl_if.dir[j];
    end
  endgenerate

  assign ADDR_HI   = CTRL_PIN_EN ? addr_reg[18:16] : 3'h0;
  assign CS_N      = cs_n_reg;
  assign WR_LO_N   = wr_lo_n_reg;
  assign WR_HI_N   = wr_hi_n_reg;
  assign RD_N      = rd_n_reg;
  assign BUS_CLK   = clk_out_reg;
  assign REQ_DONE  = done_reg;
  assign REQ_RDATA = rdata_reg;

  logic act;
  assign act = (st_reg != ebi_pkg::ST_IDLE) && (st_reg != ebi_pkg::ST_TI);

  sequence s_first_state;
    st_reg == ebi_pkg::ST_T1;
  endsequence
  sequence s_hold_two_clks;
    act [*4];
  endsequence

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N || !CE);

  AST_MIN_TWO_CLKS: assert property ($rose(act) |-> s_hold_two_clks)
    else $error("Bus cycle shorter than two bus clocks");
  AST_CS_ONEHOT: assert property ($onehot0(~CS_N))
    else $error("More than one chip select active");
  AST_INTERNAL_QUIET: assert property (take && !ext |=>
    st_reg == ebi_pkg::ST_IDLE && CS_N == 3'h7 && RD_N && REQ_DONE)
    else $error("Internal access disturbed the bus pins");
  AST_ROM_WRITE: assert property (take && REQ_WR
    && REQ_ADDR < ebi_pkg::ROM_LIMIT |=> s_first_state ##0 drive_reg
    && (!WR_LO_N || !WR_HI_N || !$past(CTRL_PIN_EN)))
    else $error("Write to ROM range not run externally");
  AST_NO_WAIT: assert property (s_first_state ##0 tick && cnt_reg == 3'h0
    && !wait_s |=> st_reg == ebi_pkg::ST_T2)
    else $error("Unrequested wait state inserted");
  AST_EXT_WAIT: assert property ((st_reg == ebi_pkg::ST_T1
    || st_reg == ebi_pkg::ST_TW) && tick && wait_s
    |=> st_reg == ebi_pkg::ST_TW)
    else $error("External wait request ignored");
  AST_IDLE_READ: assert property (st_reg == ebi_pkg::ST_T2 && tick
    && !wr_reg && idle_en_reg |=> st_reg == ebi_pkg::ST_TI)
    else $error("Idle state missing after read");
  AST_NO_IDLE_WRITE: assert property (st_reg == ebi_pkg::ST_T2 && tick
    && wr_reg |=> st_reg == ebi_pkg::ST_IDLE)
    else $error("Idle state after a write");
  AST_AREA_CS: assert property (s_first_state ##0 area_reg == 2'h1
    |-> !CS_N[1] || !CTRL_PIN_EN)
    else $error("Area one chip select not asserted");
endmodule // ebi_top
`default_nettype wire

// ==== ebi_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Slow external memory hung on the data pins
module ebi_mem_model (
  input  wire logic        clk,
  input  wire logic [18:0] addr,
  input  wire logic [2:0]  cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_lo_n,
  input  wire logic        wr_hi_n,
  input  wire logic [15:0] pins,
  input  wire logic [3:0]  wait_len,
  output var  logic [15:0] drv,
  output var  logic        wait_n
);
  logic [7:0] mem [0:511];
  logic [8:0] a;
  logic [3:0] wcnt;
  logic       sel_q;

  initial begin
    wcnt  = 4'h0;
    sel_q = 1'b0;
    drv   = 16'h0000;
  end
  assign a = addr[8:0];
  // Read data only while selected; released lines toggle so stale data shows
  always @(posedge clk) begin
    if (!rd_n && cs_n != 3'h7) begin
      drv <= {mem[{a[8:1], 1'b1}], mem[a]};
    end else begin
      drv <= ~drv;
    end
  end
  // Byte lanes written while their strobe is low, chip select or not
  always @(posedge clk) begin
    if (!wr_lo_n) begin
      mem[{a[8:1], 1'b0}] <= pins[7:0];
    end
    if (!wr_hi_n) begin
      mem[{a[8:1], 1'b1}] <= pins[15:8];
    end
  end
  // Wait held low for a set number of cycles after selection
  always @(posedge clk) begin
    sel_q <= (cs_n != 3'h7);
    if (cs_n != 3'h7 && !sel_q) begin
      wcnt <= wait_len;
    end else if (wcnt != 4'h0) begin
      wcnt <= wcnt - 4'h1;
    end
  end
  assign wait_n = (wcnt == 4'h0);
endmodule // ebi_mem_model
`default_nettype wire

// ==== external_memory_bus_interface_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module external_memory_bus_interface_bench;
  typedef struct packed {
    logic wr; logic half; logic [25:0] addr; logic [15:0] wd;
    logic [15:0] exp; logic [15:0] msk; logic [2:0] cs; logic [2:0] strb;
    int lat; int csl;
  } ebi_row_s;
  logic MCLK, RST_N, CE, REQ, REQ_WR, REQ_HALF, REQ_READY, REQ_DONE;
  logic [25:0] REQ_ADDR;
  logic [15:0] REQ_WDATA, REQ_RDATA, PORT_WDATA, PORT_RDATA;
  logic [2:0]  AREA_BUS16, AREA_IDLE_EN, PORT_BITNUM, ADDR_HI, CS_N;
  logic [8:0]  AREA_WAITS;
  logic CTRL_PIN_EN, PORT_WR, PORT_TGT_DL, PORT_BIT, PORT_HALF, PORT_WIDE;
  logic PORT_BITVAL, WR_LO_N, WR_HI_N, RD_N, BUS_CLK, WAIT_N;
  logic [1:0]  PORT_REG;
  logic [15:0] P9_IN, P9_OUT, P9_OE, DL_IN, DL_OUT, DL_OE, m_drv;
  logic [3:0]  m_wait;
  int n_errors, compares, cyc, lat, csl, gap;
  int gaps [12];
  logic [2:0]  cs_s, strb;
  logic        oe;
  logic [15:0] a_lo;
  ebi_row_s    r;
  // Rows: wr half addr wdata rdata mask cs {rd,wlo,whi} latency cs_cycles
  ebi_row_s rows [12] = '{
    '{1'b1, 1'b1, 26'h0100010, 16'h1234, 16'h0, 16'h0, 3'h6, 3'h3, 5, 4},
    '{1'b0, 1'b1, 26'h0100010, 16'h0, 16'h1234, 16'hffff, 3'h6, 3'h4, 5, 4},
    '{1'b1, 1'b0, 26'h0100011, 16'h00ab, 16'h0, 16'h0, 3'h6, 3'h1, 5, 4},
    '{1'b0, 1'b1, 26'h0180010, 16'h0, 16'hab34, 16'hffff, 3'h6, 3'h4, 5, 4},
    '{1'b1, 1'b1, 26'h0200020, 16'h5a5a, 16'h0, 16'h0, 3'h5, 3'h3, 9, 8},
    '{1'b0, 1'b1, 26'h0280020, 16'h0, 16'h5a5a, 16'hffff, 3'h5, 3'h4, 0, -1},
    '{1'b1, 1'b0, 26'h0400030, 16'h00c3, 16'h0, 16'h0, 3'h3, 3'h2, 19, 18},
    '{1'b0, 1'b0, 26'h0400030, 16'h0, 16'h00c3, 16'h00ff, 3'h3, 3'h4, 19, 18},
    '{1'b1, 1'b1, 26'h0400032, 16'h7788, 16'h0, 16'h0, 3'h3, 3'h2, 19, 18},
    '{1'b1, 1'b1, 26'h0000040, 16'hbeef, 16'h0, 16'h0, 3'h7, 3'h3, 5, 0},
    '{1'b0, 1'b1, 26'h0000040, 16'h0, 16'h0, 16'h0, 3'h7, 3'h0, 1, 0},
    '{1'b0, 1'b1, 26'h0800000, 16'h0, 16'h0, 16'h0, 3'h7, 3'h0, 1, 0}};

  // Pin levels: undriven port 9 pins sit high, data pins follow the memory
  assign P9_IN = (P9_OE & P9_OUT) | ~P9_OE;
  assign DL_IN = (DL_OE & DL_OUT) | (~DL_OE & m_drv);

  ebi_top uut (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .REQ(REQ),
    .REQ_WR(REQ_WR), .REQ_HALF(REQ_HALF), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .REQ_DONE(REQ_DONE),
    .REQ_RDATA(REQ_RDATA), .AREA_BUS16(AREA_BUS16), .AREA_WAITS(AREA_WAITS),
    .AREA_IDLE_EN(AREA_IDLE_EN), .CTRL_PIN_EN(CTRL_PIN_EN),
    .PORT_WR(PORT_WR), .PORT_TGT_DL(PORT_TGT_DL), .PORT_BIT(PORT_BIT),
    .PORT_REG(PORT_REG), .PORT_HALF(PORT_HALF), .PORT_WIDE(PORT_WIDE),
    .PORT_BITNUM(PORT_BITNUM), .PORT_BITVAL(PORT_BITVAL),
    .PORT_WDATA(PORT_WDATA), .PORT_RDATA(PORT_RDATA), .P9_IN(P9_IN),
    .P9_OUT(P9_OUT), .P9_OE(P9_OE), .DL_IN(DL_IN), .DL_OUT(DL_OUT),
    .DL_OE(DL_OE), .ADDR_HI(ADDR_HI), .CS_N(CS_N), .WR_LO_N(WR_LO_N),
    .WR_HI_N(WR_HI_N), .RD_N(RD_N), .BUS_CLK(BUS_CLK), .WAIT_N(WAIT_N));

  ebi_mem_model mem (.clk(MCLK), .addr({ADDR_HI, P9_OUT}), .cs_n(CS_N),
    .rd_n(RD_N), .wr_lo_n(WR_LO_N), .wr_hi_n(WR_HI_N), .pins(DL_IN),
    .wait_len(m_wait), .drv(m_drv), .wait_n(WAIT_N));

  always #25 MCLK = ~MCLK;

  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk16(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_i(input string nm, input int e, g);
    compares++;
    if (g != e) begin
      n_errors++;
      $display("FAIL %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // One bus access, entered just after a rising edge; pins watched at falls
  task automatic acc(input ebi_row_s r);
    lat = 0; csl = 0; gap = 0; strb = 3'h0; oe = 1'b0; cs_s = 3'h7;
    a_lo = 16'h0;
    REQ <= 1'b1; REQ_WR <= r.wr; REQ_HALF <= r.half;
    REQ_ADDR <= r.addr; REQ_WDATA <= r.wd;
    do begin
      @(negedge MCLK);
      gap++;
    end while (REQ_READY !== 1'b1);
    @(posedge MCLK);
    REQ <= 1'b0;
    do begin
      @(negedge MCLK);
      lat++;
      if (CS_N !== 3'h7) begin
        csl++;
        cs_s = CS_N;
      end
      strb = strb | {~RD_N, ~WR_LO_N, ~WR_HI_N};
      oe = oe | (|DL_OE);
      if (!RD_N || !WR_LO_N || !WR_HI_N) a_lo = P9_OUT;
    end while (REQ_DONE !== 1'b1 && lat < 100);
    // A lost done pulse counts as a mismatch
    if (REQ_DONE !== 1'b1) n_errors++;
    @(posedge MCLK);
  endtask

  task automatic pw(input logic tgt, input logic [1:0] rg, input logic wide,
                    input logic bop, input logic [15:0] d);
    PORT_WR <= 1'b1; PORT_TGT_DL <= tgt; PORT_REG <= rg; PORT_WIDE <= wide;
    PORT_BIT <= bop; PORT_BITNUM <= 3'h0; PORT_BITVAL <= 1'b1;
    PORT_WDATA <= d;
    @(posedge MCLK);
    PORT_WR <= 1'b0; PORT_BIT <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic pr(input logic tgt, input logic [1:0] rg,
                    input logic [15:0] e);
    PORT_TGT_DL <= tgt; PORT_REG <= rg;
    repeat (4) @(posedge MCLK);
    @(negedge MCLK);
    chk16("port_rdata", e, PORT_RDATA);
    @(posedge MCLK);
  endtask

  // Pins idle in reset: strobes high, bus clock low, nothing driven
  task automatic rst_chk;
    @(negedge MCLK);
    chk16("idle_pins", 16'h00fc,
          {8'h0, CS_N, RD_N, WR_LO_N, WR_HI_N, BUS_CLK, REQ_DONE});
    chk16("pin_oe", 16'h0000, P9_OE | DL_OE);
  endtask

  // Hang guard, well beyond the few hundred cycles the run needs
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    MCLK = 1'b0; RST_N = 1'b0; CE = 1'b1; REQ = 1'b0; REQ_WR = 1'b0;
    REQ_HALF = 1'b0; REQ_ADDR = 26'h0; REQ_WDATA = 16'h0;
    AREA_BUS16 = 3'h3; AREA_WAITS = {3'h7, 3'h2, 3'h0};
    AREA_IDLE_EN = 3'h2; CTRL_PIN_EN = 1'b1; PORT_WR = 1'b0;
    PORT_TGT_DL = 1'b0; PORT_BIT = 1'b0; PORT_REG = 2'h0; PORT_HALF = 1'b0;
    PORT_WIDE = 1'b0; PORT_BITNUM = 3'h0; PORT_BITVAL = 1'b0;
    PORT_WDATA = 16'h0; m_wait = 4'h0; n_errors = 0; compares = 0; cyc = 0;
    repeat (16) @(posedge MCLK);
    rst_chk();
    chk16("port_rdata", 16'h0000, PORT_RDATA);
    @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    // Hand the address and data pins to the bus
    pw(1'b0, ebi_pkg::REG_FUNC, 1'b1, 1'b0, 16'h0000);
    pw(1'b0, ebi_pkg::REG_MODE, 1'b1, 1'b0, 16'hffff);
    pw(1'b1, ebi_pkg::REG_MODE, 1'b1, 1'b0, 16'hffff);
    pr(1'b0, ebi_pkg::REG_MODE, 16'hffff);
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      acc(r);
      gaps[i] = gap;
      chk16("cs", {13'h0, r.cs}, {13'h0, cs_s});
      chk16("strobes", {13'h0, r.strb}, {13'h0, strb});
      chk16("data_oe", {15'h0, r.wr && r.strb != 3'h0}, {15'h0, oe});
      chk16("rdata", r.exp & r.msk, REQ_RDATA & r.msk);
      if (r.lat > 0) chk_i("latency", r.lat, lat);
      if (r.csl >= 0) chk_i("cs_cycles", r.csl, csl);
      if (r.strb != 3'h0) chk16("addr", r.addr[15:0], a_lo);
    end
    chk_i("idle_gap", gaps[5] + 2, gaps[6]);
    chk16("rom_write", 16'hbeef, {mem.mem[9'h41], mem.mem[9'h40]});
    chk16("narrow_hi", 16'h0088, {8'h0, mem.mem[9'h32]});
    // Slow device holds wait: cycle stretched in whole wait states
    // Area one has programmed waits, so the synced pin meets a wait tick
    m_wait <= 4'ha;
    acc(rows[5]);
    chk_i("stretch", 1, int'(lat > 9 && lat < 40));
    chk_i("stretch_even", 0, csl % 2);
    chk16("wait_rdata", 16'h5a5a, REQ_RDATA);
    m_wait <= 4'h0;
    // Bus pins parked when their control function is off
    CTRL_PIN_EN <= 1'b0;
    @(posedge MCLK);
    repeat (2) begin
      @(negedge MCLK);
      chk16("pins_off", 16'h03f0, {6'h0, CS_N, RD_N, WR_LO_N, WR_HI_N,
            BUS_CLK, ADDR_HI});
    end
    @(posedge MCLK);
    CTRL_PIN_EN <= 1'b1;
    // Mixed port: bit 0 output, rest inputs seeing high pins
    pw(1'b0, ebi_pkg::REG_MODE, 1'b1, 1'b0, 16'h0000);
    pw(1'b0, ebi_pkg::REG_DIR, 1'b1, 1'b0, 16'hfffe);
    pw(1'b0, ebi_pkg::REG_LATCH, 1'b1, 1'b0, 16'h0000);
    pr(1'b0, ebi_pkg::REG_LATCH, 16'hfffe);
    pw(1'b0, ebi_pkg::REG_LATCH, 1'b0, 1'b1, 16'h0000);
    pw(1'b0, ebi_pkg::REG_DIR, 1'b1, 1'b0, 16'h0000);
    pr(1'b0, ebi_pkg::REG_LATCH, 16'h00ff);
    // Latch rewritten before relying on the outputs
    pw(1'b0, ebi_pkg::REG_LATCH, 1'b1, 1'b0, 16'h0001);
    @(negedge MCLK);
    chk16("p9_out", 16'h0001, P9_OUT & P9_OE);
    // Clock enable low: a latch write must not land
    @(posedge MCLK);
    CE <= 1'b0;
    pw(1'b0, ebi_pkg::REG_LATCH, 1'b1, 1'b0, 16'h00f0);
    CE <= 1'b1;
    @(negedge MCLK);
    chk16("ce_freeze", 16'h0001, P9_OUT & P9_OE);
    // Reset dropped in mid-cycle returns every pin to idle
    @(posedge MCLK);
    REQ <= 1'b1; REQ_WR <= 1'b0; REQ_ADDR <= 26'h0100010;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b0; REQ <= 1'b0;
    repeat (2) @(posedge MCLK);
    rst_chk();
    complete_run();
  end
endmodule // external_memory_bus_interface_bench
`default_nettype wire
